// ---- rtl/uart_sfeat_regs.vh ----
// Offsets, field positions, reset values and keys of the special
// feature register set. Definitions only.
`ifndef UART_SFEAT_REGS_VH
`define UART_SFEAT_REGS_VH

// Register offsets
`define OFS_FLOW_STATUS 4'h2
`define OFS_LINE_CTRL 4'h3
`define OFS_PRESCALER 4'h4
`define OFS_RX_COUNT 4'h5
`define OFS_TX_COUNT 4'h6
`define OFS_SFUNC 4'h7
`define OFS_IDLE_TIME 4'h8
`define OFS_TXRX_CTRL 4'h9
`define OFS_UNLOCK 4'hD
`define OFS_IRQ_EXTRA 4'hF

// Access keys
`define KEY_LINE_CTRL 8'hBF
`define KEY_UNLOCK 8'h5A

// Reset values
`define RST_PRESCALER 8'h10
`define RST_TXRX_CTRL 8'h06
`define RST_ZERO 8'h00

// Special function register fields
`define SF_RX_ERR_SEL 6
`define SF_BURST 4
`define SF_LOOPBACK 3
`define SF_SPECIAL 2
`define SF_AUTO_DSR 1
`define SF_FORCE_TX 0

// Extra feature low bits
`define EF_TX_DIS 2
`define EF_RX_DIS 1
`define EF_MULTIDROP 0

// Transmit/receive control fields
`define TC_XON 3
`define TC_TX_EMPTY 2
`define TC_RX_TMO 1
`define TC_IDLE 0

// Interrupt status clear bit
`define IRQ_CLEAR 0

// Sample clock base count
`define SAMPLE_BASE 5'h10

`endif

// ---- rtl/uart_sfeat.v ----
// Special feature register set of a host-attached serial port:
// gated access, counters, baud tick, interrupt flags and line controls.
// Assumes a host port front end presenting single-cycle read/write
// strobes on i_clk, and a serial core on the same clock.
`timescale 1ns/100ps
`include "uart_sfeat_regs.vh"

module uart_sfeat (
    // Clock and reset
    input wire i_clk,
    input wire i_nrst,
    // Register port from host front end
    input wire [3:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    // Baud generator inputs and tick output
    input wire [15:0] i_baud_divisor,
    input wire i_mcr7,
    output reg o_baud_tick,
    // FIFO activity from the serial core
    input wire i_rx_push,
    input wire i_rx_push_err,
    input wire i_rx_pop,
    input wire i_rx_pop_err,
    input wire i_tx_push,
    input wire i_tx_pop,
    // Transmitter and flow state
    input wire i_tx_shift_busy,
    input wire [1:0] i_flow_state,
    input wire i_stop_sent,
    input wire i_remote_term,
    // Interrupt source events, bits 7..1
    input wire [7:1] i_irq_event,
    // Controls to the serial core
    output reg o_tx_allow,
    output reg o_rx_enable,
    output reg o_nine_bit,
    output reg o_burst_en,
    output reg o_loopback,
    output reg o_auto_dsr_dtr,
    output reg o_force_tx,
    output reg o_xon_inband,
    output reg o_tx_empty_irq_en,
    output reg o_rx_timeout_en,
    output reg o_idle_insert_en,
    output reg [7:0] o_idle_time
);

    // Stored registers
    reg [7:0] line_control_reg;
    reg [7:0] feature_unlock_key;
    reg [7:0] special_function_ctrl;
    reg [7:0] baud_prescaler;
    reg [7:0] tx_idle_time;
    reg [7:0] txrx_sample_ctrl;
    reg [2:0] extra_feature_ctrl;
    reg [7:1] irq_flags;
    reg [7:0] advanced_flow_status;
    reg [7:0] rx_fifo_fill_count;
    reg [7:0] rx_error_byte_count;
    reg [7:0] tx_fifo_fill_count;
    reg [39:0] baud_count;
    reg [7:0] next_rdata;

    // Access gates
    wire lcr_key = (line_control_reg == `KEY_LINE_CTRL);
    wire sf_open = lcr_key && (feature_unlock_key == `KEY_UNLOCK);
    wire sp_open = lcr_key && special_function_ctrl[`SF_SPECIAL];
    wire wr_lcr = i_reg_wr && (i_reg_addr == `OFS_LINE_CTRL);
    wire wr_unl = i_reg_wr && lcr_key && (i_reg_addr == `OFS_UNLOCK);
    wire wr_sf = i_reg_wr && sf_open && (i_reg_addr == `OFS_SFUNC);
    wire wr_sp = i_reg_wr && sp_open;
    wire wr_irq = wr_sp && (i_reg_addr == `OFS_IRQ_EXTRA);
    wire wr_ext = i_reg_wr && !special_function_ctrl[`SF_SPECIAL] &&
                  (i_reg_addr == `OFS_IRQ_EXTRA);

    // Up/down occupancy step shared by the three FIFO counters
    function [7:0] step_count;
        input [7:0] cnt;
        input inc;
        input dec;
        begin
            if (inc && !dec)
                step_count = cnt + 8'h01;
            else if (dec && !inc && cnt != 8'h00)
                step_count = cnt - 8'h01;
            else
                step_count = cnt;
        end
    endfunction

    // Bit period in clock cycles. An exponent that would be -1 is held at
    // 0; software keeping the factor above one avoids a degenerate tick.
    wire [4:0] samp_factor = `SAMPLE_BASE - {1'b0, txrx_sample_ctrl[7:4]}
                             + {1'b0, baud_prescaler[3:0]};
    wire [4:0] exp_raw = {1'b0, baud_prescaler[7:4]} + {2'b00, i_mcr7, 1'b0};
    wire [4:0] exp_val = (exp_raw == 5'h00) ? 5'h00 : exp_raw - 5'h01;
    wire [39:0] scaled = {35'h0, samp_factor} << exp_val;
    // Full-width product so no bits of the period are lost
    wire [55:0] period_full = {16'h0000, scaled} * {40'h0, i_baud_divisor};
    wire [39:0] period = period_full[39:0];

    // Configuration registers with their access gates
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            line_control_reg <= `RST_ZERO;
            feature_unlock_key <= `RST_ZERO;
            special_function_ctrl <= `RST_ZERO;
            baud_prescaler <= `RST_PRESCALER;
            tx_idle_time <= `RST_ZERO;
            txrx_sample_ctrl <= `RST_TXRX_CTRL;
            extra_feature_ctrl <= 3'h0;
        end else begin
            if (wr_lcr)
                line_control_reg <= i_reg_wdata;
            if (wr_unl)
                feature_unlock_key <= i_reg_wdata;
            if (wr_sf)
                special_function_ctrl <= i_reg_wdata;
            if (wr_sp && i_reg_addr == `OFS_PRESCALER)
                baud_prescaler <= i_reg_wdata;
            if (wr_sp && i_reg_addr == `OFS_IDLE_TIME)
                tx_idle_time <= i_reg_wdata;
            if (wr_sp && i_reg_addr == `OFS_TXRX_CTRL)
                txrx_sample_ctrl <= i_reg_wdata;
            if (wr_ext)
                extra_feature_ctrl <= i_reg_wdata[2:0];
        end
    end

    // Sticky interrupt flags; a source event beats a same-cycle clear
    always @(posedge i_clk) begin
        if (!i_nrst)
            irq_flags <= 7'h00;
        else if (wr_irq && i_reg_wdata[`IRQ_CLEAR])
            irq_flags <= i_irq_event;
        else
            irq_flags <= irq_flags | i_irq_event;
    end

    // Flow status snapshot of the core's state
    always @(posedge i_clk) begin
        if (!i_nrst)
            advanced_flow_status <= `RST_ZERO;
        else
            advanced_flow_status <= {2'b00, i_flow_state, 2'b00,
                                     i_stop_sent, i_remote_term};
    end

    // FIFO occupancy counters
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            rx_fifo_fill_count <= `RST_ZERO;
            rx_error_byte_count <= `RST_ZERO;
            tx_fifo_fill_count <= `RST_ZERO;
        end else begin
            rx_fifo_fill_count <= step_count(rx_fifo_fill_count,
                                             i_rx_push, i_rx_pop);
            rx_error_byte_count <= step_count(rx_error_byte_count,
                i_rx_push && i_rx_push_err,
                i_rx_pop && i_rx_pop_err);
            tx_fifo_fill_count <= step_count(tx_fifo_fill_count,
                                             i_tx_push, i_tx_pop);
        end
    end

    // Baud tick: one pulse per bit period
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            baud_count <= 40'h0;
            o_baud_tick <= 1'b0;
        end else if (baud_count + 40'h1 >= period) begin
            baud_count <= 40'h0;
            o_baud_tick <= 1'b1;
        end else begin
            baud_count <= baud_count + 40'h1;
            o_baud_tick <= 1'b0;
        end
    end

    // Read mux; closed or unmapped offsets read zero
    always @* begin
        next_rdata = `RST_ZERO;
        if (i_reg_addr == `OFS_LINE_CTRL)
            next_rdata = line_control_reg;
        else if (i_reg_addr == `OFS_UNLOCK && lcr_key)
            next_rdata = feature_unlock_key;
        else if (i_reg_addr == `OFS_SFUNC && sf_open)
            next_rdata = special_function_ctrl;
        else if (i_reg_addr == `OFS_IRQ_EXTRA && !sp_open &&
                 !special_function_ctrl[`SF_SPECIAL])
            next_rdata = {5'h00, extra_feature_ctrl};
        else if (sp_open) begin
            if (i_reg_addr == `OFS_FLOW_STATUS)
                next_rdata = advanced_flow_status;
            else if (i_reg_addr == `OFS_PRESCALER)
                next_rdata = baud_prescaler;
            else if (i_reg_addr == `OFS_RX_COUNT)
                next_rdata = special_function_ctrl[`SF_RX_ERR_SEL] ?
                    rx_error_byte_count : rx_fifo_fill_count;
            else if (i_reg_addr == `OFS_TX_COUNT)
                next_rdata = tx_fifo_fill_count;
            else if (i_reg_addr == `OFS_IDLE_TIME)
                next_rdata = tx_idle_time;
            else if (i_reg_addr == `OFS_TXRX_CTRL)
                next_rdata = txrx_sample_ctrl;
            else if (i_reg_addr == `OFS_IRQ_EXTRA)
                next_rdata = {irq_flags, 1'b0};
        end
    end

    // Registered read data holds until the next read
    always @(posedge i_clk) begin
        if (!i_nrst)
            o_reg_rdata <= `RST_ZERO;
        else if (i_reg_rd)
            o_reg_rdata <= next_rdata;
    end

    // Control outputs to the core. A transmit disable while a character is shifting
    // keeps the permit until the shift register empties, so no character
    // is cut short on the line.
    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_tx_allow <= 1'b1;
            o_rx_enable <= 1'b1;
            o_nine_bit <= 1'b0;
            o_burst_en <= 1'b0;
            o_loopback <= 1'b0;
            o_auto_dsr_dtr <= 1'b0;
            o_force_tx <= 1'b0;
            o_xon_inband <= 1'b0;
            o_tx_empty_irq_en <= 1'b1;
            o_rx_timeout_en <= 1'b1;
            o_idle_insert_en <= 1'b0;
            o_idle_time <= `RST_ZERO;
        end else begin
            o_tx_allow <= !extra_feature_ctrl[`EF_TX_DIS] ||
                          (o_tx_allow && i_tx_shift_busy);
            o_rx_enable <= !extra_feature_ctrl[`EF_RX_DIS];
            o_nine_bit <= extra_feature_ctrl[`EF_MULTIDROP];
            o_burst_en <= special_function_ctrl[`SF_BURST];
            o_loopback <= special_function_ctrl[`SF_LOOPBACK];
            o_auto_dsr_dtr <= special_function_ctrl[`SF_AUTO_DSR];
            o_force_tx <= special_function_ctrl[`SF_FORCE_TX];
            o_xon_inband <= txrx_sample_ctrl[`TC_XON];
            o_tx_empty_irq_en <= txrx_sample_ctrl[`TC_TX_EMPTY];
            o_rx_timeout_en <= txrx_sample_ctrl[`TC_RX_TMO];
            o_idle_insert_en <= txrx_sample_ctrl[`TC_IDLE];
            o_idle_time <= tx_idle_time;
        end
    end

endmodule

// ---- dv/serial_core_model.sv ----
// Behavioural transmit shift register of the serial core.
// Assumes the bench pulses i_kick for one cycle per character.
`timescale 1ns/100ps
module serial_core_model (
    // Clock and request
    input wire i_clk,
    input wire i_kick,
    input wire i_tx_allow,
    // Shift state
    output reg o_busy,
    output reg o_pop
);
    reg [3:0] left;
    initial begin
        o_busy = 1'b0;
        o_pop = 1'b0;
        left = 4'h0;
    end
    // Starts a character only while sending is allowed, as a core would
    always @(posedge i_clk) begin
        o_pop <= i_kick && i_tx_allow && !o_busy;
        if (i_kick && i_tx_allow && !o_busy) begin
            o_busy <= 1'b1;
            left <= 4'hA;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
            o_busy <= (left != 4'h1);
        end
    end
endmodule

// ---- dv/uart_sfeat_props.sv ----
// Port-level checker of the special feature register block.
// Assumes it is bound to uart_sfeat and sees only its ports.
`timescale 1ns/100ps
module uart_sfeat_props (
    // Watched ports
    input wire i_clk,
    input wire i_nrst,
    input wire [3:0] i_reg_addr,
    input wire i_reg_wr,
    input wire i_reg_rd,
    input wire [7:0] o_reg_rdata,
    input wire o_baud_tick,
    input wire i_tx_shift_busy,
    input wire o_tx_allow,
    input wire o_rx_enable,
    input wire o_loopback,
    input wire [7:0] o_idle_time
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Sending stops only with the shift register empty
    tx_stop_a: assert property ($fell(o_tx_allow) |->
        !$past(i_tx_shift_busy)) else $error("tx stopped mid character");
    tx_resume_a: assert property ($rose(o_tx_allow) |->
        $past(i_reg_wr) || $past(i_reg_wr, 2)) else $error("tx resumed");
    rx_gate_a: assert property ($changed(o_rx_enable) |->
        $past(i_reg_wr) || $past(i_reg_wr, 2)) else $error("rx enable moved");
    loop_gate_a: assert property ($changed(o_loopback) |->
        $past(i_reg_wr) || $past(i_reg_wr, 2)) else $error("loopback moved");
    idle_gate_a: assert property ($changed(o_idle_time) |->
        $past(i_reg_wr) || $past(i_reg_wr, 2)) else $error("idle time moved");
    // Read data only moves after a read
    rd_hold_a: assert property (!i_reg_rd |=>
        $stable(o_reg_rdata)) else $error("read data moved");
    unmapped_rd_a: assert property (i_reg_rd && (i_reg_addr inside
        {4'h0, 4'h1, 4'hA, 4'hB, 4'hC, 4'hE}) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    flow_rsvd_a: assert property (i_reg_rd && i_reg_addr == 4'h2 |=>
        (o_reg_rdata & 8'hCC) == 8'h00) else $error("flow reserved set");
    cover property (i_reg_wr && i_reg_addr == 4'hF);
    cover property ($fell(o_tx_allow));
    cover property (o_baud_tick);
endmodule
bind uart_sfeat uart_sfeat_props chk (.*);

// ---- dv/uart_sfeat_tb_top.sv ----
// Self-checking bench of the special feature register block.
// Assumes the core model stands in for the transmit shift register.
`timescale 1ns/100ps
`include "uart_sfeat_regs.vh"
module uart_sfeat_tb_top;
    reg i_clk, i_nrst, i_reg_wr, i_reg_rd, i_mcr7, kick;
    reg [3:0] i_reg_addr;
    reg [7:0] i_reg_wdata;
    reg [15:0] i_baud_divisor;
    reg i_rx_push, i_rx_push_err, i_rx_pop, i_rx_pop_err, i_tx_push;
    reg [1:0] i_flow_state;
    reg i_stop_sent, i_remote_term;
    reg [7:1] i_irq_event;
    wire [7:0] o_reg_rdata, o_idle_time;
    wire o_baud_tick, o_tx_allow, o_rx_enable, o_nine_bit, o_burst_en;
    wire o_loopback, o_auto_dsr_dtr, o_force_tx, o_xon_inband;
    wire o_tx_empty_irq_en, o_rx_timeout_en, o_idle_insert_en;
    wire i_tx_shift_busy, i_tx_pop;
    integer n_errors, num_checks, k;
    uart_sfeat uut (.*);
    serial_core_model core (.i_clk(i_clk), .i_kick(kick),
        .i_tx_allow(o_tx_allow), .o_busy(i_tx_shift_busy), .o_pop(i_tx_pop));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task chk(input [79:0] nm, input [7:0] exp, input [7:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    // Bus cycles: a quiet edge that raises the strobe, then the edge that samples it
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge i_clk);
            i_reg_addr <= a;
            i_reg_wdata <= d;
            i_reg_wr <= 1'b1;
            @(posedge i_clk);
            i_reg_wr <= 1'b0;
        end
    endtask
    task rdc(input [3:0] a, input [7:0] exp);
        begin
            @(posedge i_clk);
            i_reg_addr <= a;
            i_reg_rd <= 1'b1;
            @(posedge i_clk);
            i_reg_rd <= 1'b0;
            #1 chk("rdata", exp, o_reg_rdata);
        end
    endtask
    task settle;
        begin
            repeat (2) @(posedge i_clk);
            #1;
        end
    endtask
    task pulse_rx(input e, input t);
        begin
            @(posedge i_clk);
            i_rx_push <= 1'b1;
            i_rx_push_err <= e;
            i_tx_push <= t;
            @(posedge i_clk);
            {i_rx_push, i_rx_push_err, i_tx_push} <= 3'b000;
        end
    endtask
    // Ticks counted between two sightings of the baud pulse
    task t_baud(input m7, input [7:0] exp);
        begin
            i_mcr7 <= m7;
            repeat (2) begin
                k = 0;
                do begin
                    @(posedge i_clk);
                    #1 k = k + 1;
                end while (!o_baud_tick && k < 300);
            end
            chk("baud", exp, k[7:0]);
        end
    endtask
    task t_irq(input [7:1] ev);
        begin
            @(posedge i_clk);
            i_irq_event <= ev;
            @(posedge i_clk);
            i_irq_event <= 7'h00;
            rdc(`OFS_IRQ_EXTRA, {ev, 1'b0});
            wr(`OFS_IRQ_EXTRA, 8'h01);
            rdc(`OFS_IRQ_EXTRA, 8'h00);
        end
    endtask
    task t_tx_disable;
        begin
            wr(`OFS_SFUNC, 8'h00);
            wr(`OFS_IRQ_EXTRA, 8'h07);
            settle;
            chk("lines", 8'h01,
                {o_tx_allow, o_rx_enable, o_nine_bit});
            wr(`OFS_IRQ_EXTRA, 8'h00);
            @(posedge i_clk);
            kick <= 1'b1;
            @(posedge i_clk);
            kick <= 1'b0;
            wr(`OFS_IRQ_EXTRA, 8'h04);
            settle;
            chk("midchar", 8'h01, {7'h00, o_tx_allow});
            k = 0;
            while (i_tx_shift_busy && k < 40) begin
                @(posedge i_clk);
                #1 k = k + 1;
            end
            settle;
            chk("stopped", 8'h00, {7'h00, o_tx_allow});
            wr(`OFS_IRQ_EXTRA, 8'h00);
            settle;
            chk("resume", 8'h03,
                {6'h00, o_tx_allow, o_rx_enable});
        end
    endtask
    initial begin
        #50000 n_errors = n_errors + 1;
        report_and_stop;
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        {i_nrst, i_reg_wr, i_reg_rd, i_mcr7, kick, i_rx_push} = 6'h00;
        {i_rx_push_err, i_rx_pop, i_rx_pop_err, i_tx_push} = 4'h0;
        {i_stop_sent, i_remote_term, i_flow_state} = 4'h0;
        {i_reg_addr, i_reg_wdata, i_irq_event} = 19'h00000;
        i_baud_divisor = 16'h0001;
        repeat (6) @(posedge i_clk);
        i_nrst <= 1'b1;
        #1 chk("rstctl", 8'hF0, {o_tx_allow, o_rx_enable,
            o_tx_empty_irq_en, o_rx_timeout_en, o_xon_inband,
            o_idle_insert_en, o_burst_en, o_loopback});
        t_baud(1'b0, 8'h10);
        t_baud(1'b1, 8'h40);
        i_mcr7 <= 1'b0;
        rdc(`OFS_PRESCALER, 8'h00);
        wr(`OFS_LINE_CTRL, `KEY_LINE_CTRL);
        wr(`OFS_SFUNC, 8'h04);
        rdc(`OFS_SFUNC, 8'h00);
        wr(`OFS_UNLOCK, `KEY_UNLOCK);
        rdc(`OFS_UNLOCK, 8'h5A);
        wr(`OFS_SFUNC, 8'h04);
        rdc(`OFS_SFUNC, 8'h04);
        rdc(`OFS_PRESCALER, 8'h10);
        rdc(`OFS_TXRX_CTRL, 8'h06);
        rdc(4'hE, 8'h00);
        wr(`OFS_PRESCALER, 8'h2A);
        rdc(`OFS_PRESCALER, 8'h2A);
        wr(`OFS_IDLE_TIME, 8'h33);
        wr(`OFS_TXRX_CTRL, 8'h09);
        wr(`OFS_SFUNC, 8'h1F);
        settle;
        chk("idle", 8'h33, o_idle_time);
        chk("ctl", 8'h9F, {o_xon_inband, o_tx_empty_irq_en,
            o_rx_timeout_en, o_idle_insert_en, o_burst_en, o_loopback,
            o_auto_dsr_dtr, o_force_tx});
        pulse_rx(1'b1, 1'b1);
        pulse_rx(1'b0, 1'b1);
        pulse_rx(1'b0, 1'b0);
        rdc(`OFS_RX_COUNT, 8'h03);
        rdc(`OFS_TX_COUNT, 8'h02);
        wr(`OFS_SFUNC, 8'h5F);
        rdc(`OFS_RX_COUNT, 8'h01);
        @(posedge i_clk);
        {i_rx_pop, i_rx_pop_err} <= 2'b11;
        @(posedge i_clk);
        {i_rx_pop, i_rx_pop_err} <= 2'b00;
        rdc(`OFS_RX_COUNT, 8'h00);
        {i_flow_state, i_stop_sent, i_remote_term} <= 4'hB;
        rdc(`OFS_FLOW_STATUS, 8'h23);
        t_irq(7'h55);
        t_irq(7'h2A);
        t_tx_disable;
        report_and_stop;
    end
endmodule
